// ---- piv_top.sv ----
`timescale 1ns/1ps

// Operation
// - forward request, level and vector to CPU
// - each maskable source has eight-level priority
// - highest programmed level wins
// - equal levels: smaller vector number wins
// - slot address is base plus 4n; base 0x8000
// - slot 0 reset for all reset causes
// - slot 2 watchdog NMI; slot 1 misalignment
// - slots 3 and 6 never driven
// - vectors 4, 5, 8: supply, port, RTC
// - vector 7 merges clock generator causes
// - timer underflows on vectors 9,11,15,16
// - vector 10 merges UART causes
// - vector 12 merges serial port causes
// - vector 13 merges I2C causes
// - vector 14 merges PWM timer causes
// - level field 3 bits, resets to 0
// - newer higher source replaces outputs, older held
// - cleared flag drops pending request silently
// - losers stay pending while their source holds

module piv_top (
    input  wire logic                         clk_sys_i,
    input  wire logic                         reset_n_i,
    input  wire logic                         sync_clr_i,
    // priority level write port
    input  wire logic                         lvl_wr_i,
    input  wire logic [piv_pkg::VEC_W-1:0]    lvl_sel_i,
    input  wire logic [piv_pkg::LVL_W-1:0]    lvl_data_i,
    // table base write port, bits above the fixed low byte
    input  wire logic                         tb_wr_i,
    input  wire logic [piv_pkg::ADDR_W-piv_pkg::TB_LO_W-1:0] tb_data_i,
    // reset and exception causes
    input  wire logic                         rst_pin_n_i,
    input  wire logic                         por_i,
    input  wire logic                         key_rst_i,
    input  wire logic                         supply_rst_i,
    input  wire logic                         wdt_ovf_i,
    input  wire logic                         wdt_nmi_sel_i,
    input  wire logic                         misalign_i,
    // maskable peripheral causes, flag and enable already combined
    input  wire logic                         supply_low_i,
    input  wire logic                         port_irq_i,
    input  wire logic [piv_pkg::CLG_N-1:0]    clkgen_cause_i,
    input  wire logic [piv_pkg::RTC_N-1:0]    rtc_cause_i,
    input  wire logic [piv_pkg::TMR_N-1:0]    tmr_unf_i,
    input  wire logic [piv_pkg::UART_N-1:0]   uart_cause_i,
    input  wire logic [piv_pkg::SSP_N-1:0]    ssp_cause_i,
    input  wire logic [piv_pkg::I2C_N-1:0]    i2c_cause_i,
    input  wire logic [piv_pkg::PWM_N-1:0]    pwm_cause_i,
    // toward the CPU
    output logic                              irq_req_o,
    output logic [piv_pkg::LVL_W-1:0]         irq_level_o,
    output logic [piv_pkg::VEC_W-1:0]         irq_vector_o,
    output logic [piv_pkg::ADDR_W-1:0]        irq_addr_o,
    output logic [piv_pkg::NUM_VEC-1:0]       pending_o,
    output logic                              exc_req_o,
    output logic [piv_pkg::VEC_W-1:0]         exc_vector_o,
    output logic [piv_pkg::ADDR_W-1:0]        exc_addr_o,
    output logic [piv_pkg::ADDR_W-1:0]        table_base_o
);
    import piv_pkg::*;

    localparam int TB_HI_W = ADDR_W - TB_LO_W;

    ////////////////////////////////////////////////////////////////////
    // helpers

    function automatic logic is_maskable(input logic [VEC_W-1:0] v);
        is_maskable = (v >= VEC_SUPPLY) && (v <= VEC_TMR3) &&
                      (v != VEC_UNUSED);
    endfunction

    function automatic logic [ADDR_W-1:0] slot_addr(
        input logic [TB_HI_W-1:0] base_hi,
        input logic [VEC_W-1:0]   v
    );
        logic [ADDR_W-1:0] off;
        off = ADDR_W'(v) << SLOT_SH;
        slot_addr = {base_hi, {TB_LO_W{1'b0}}} + off;
    endfunction

    ////////////////////////////////////////////////////////////////////
    // configuration state

    logic [LVL_W-1:0]   lvl_q [NUM_VEC];
    logic [TB_HI_W-1:0] tb_q;
    logic               lvl_wr_ok;

    localparam logic [TB_HI_W-1:0] TB_HI_RESET = TB_RESET[ADDR_W-1:TB_LO_W];

    // unmapped or fixed slots silently ignore level writes
    assign lvl_wr_ok = lvl_wr_i && (lvl_sel_i < VEC_W'(NUM_VEC)) &&
                       is_maskable(lvl_sel_i);

    generate
        for (genvar v = 0; v < NUM_VEC; v++) begin : g_lvl
            logic hit;
            assign hit = lvl_wr_ok && (lvl_sel_i == VEC_W'(v));
            always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
                if (!reset_n_i) begin
                    lvl_q[v] <= LVL_RESET;
                end else if (hit) begin
                    lvl_q[v] <= lvl_data_i;
                end
            end
        end
    endgenerate

    always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            tb_q <= TB_HI_RESET;
        end else if (tb_wr_i) begin
            tb_q <= tb_data_i;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // source merging

    logic [NUM_VEC-1:0] src_req;

    assign src_req[VEC_RESET]    = 1'b0;
    assign src_req[VEC_MISALIGN] = 1'b0;
    assign src_req[VEC_NMI]      = 1'b0;
    assign src_req[VEC_COMPILER] = 1'b0;
    assign src_req[VEC_SUPPLY]   = supply_low_i;
    assign src_req[VEC_PORT]     = port_irq_i;
    assign src_req[VEC_UNUSED]   = 1'b0;
    assign src_req[VEC_CLKGEN]   = |clkgen_cause_i;
    assign src_req[VEC_RTC]      = |rtc_cause_i;
    assign src_req[VEC_TMR0]     = tmr_unf_i[0];
    assign src_req[VEC_UART]     = |uart_cause_i;
    assign src_req[VEC_TMR1]     = tmr_unf_i[1];
    assign src_req[VEC_SSP]      = |ssp_cause_i;
    assign src_req[VEC_I2C]      = |i2c_cause_i;
    assign src_req[VEC_PWM]      = |pwm_cause_i;
    assign src_req[VEC_TMR2]     = tmr_unf_i[2];
    assign src_req[VEC_TMR3]     = tmr_unf_i[3];

    ////////////////////////////////////////////////////////////////////
    // arbitration

    logic [NUM_VEC*LVL_W-1:0] lvl_flat;
    logic                     arb_hit;
    logic [LVL_W-1:0]         arb_level;
    logic [VEC_W-1:0]         arb_index;

    generate
        for (genvar v = 0; v < NUM_VEC; v++) begin : g_flat
            assign lvl_flat[v*LVL_W +: LVL_W] = lvl_q[v];
        end
    endgenerate

    // combinational every cycle, so a newly raised higher source takes
    // the registered outputs at the next edge and a dropped flag vanishes without an irq
    piv_arbiter #(
        .N  (NUM_VEC),
        .LW (LVL_W),
        .VW (VEC_W)
    ) u_arb (
        .req_i   (src_req),
        .level_i (lvl_flat),
        .hit_o   (arb_hit),
        .level_o (arb_level),
        .index_o (arb_index)
    );

    ////////////////////////////////////////////////////////////////////
    // reset and exception causes

    logic rst_pin_s1_q;
    logic rst_pin_s2_q;
    logic rst_cause;
    logic nmi_cause;
    logic exc_any;
    logic [VEC_W-1:0] exc_vec;

    // external pin crosses in through two flops
    always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            rst_pin_s1_q <= 1'b1;
            rst_pin_s2_q <= 1'b1;
        end else begin
            rst_pin_s1_q <= rst_pin_n_i;
            rst_pin_s2_q <= rst_pin_s1_q;
        end
    end

    assign rst_cause = !rst_pin_s2_q || por_i || key_rst_i ||
                       supply_rst_i ||
                       (wdt_ovf_i && !wdt_nmi_sel_i);
    assign nmi_cause = wdt_ovf_i && wdt_nmi_sel_i;
    assign exc_any   = rst_cause || misalign_i || nmi_cause;
    // reset outranks misalignment, which outranks the NMI
    assign exc_vec = rst_cause  ? VEC_RESET :
                     misalign_i ? VEC_MISALIGN :
                                  VEC_NMI;

    ////////////////////////////////////////////////////////////////////
    // registered outputs

    logic                     req_q;
    logic [LVL_W-1:0]         level_q;
    logic [VEC_W-1:0]         vector_q;
    logic [ADDR_W-1:0]        addr_q;
    logic [NUM_VEC-1:0]       pend_q;
    logic                     exc_req_q;
    logic [VEC_W-1:0]         exc_vec_q;
    logic [ADDR_W-1:0]        exc_addr_q;
    logic [NUM_VEC-1:0]       pend_d;
    logic [NUM_VEC-1:0]       lvl_live;

    generate
        for (genvar v = 0; v < NUM_VEC; v++) begin : g_live
            assign lvl_live[v] = lvl_q[v] != LVL_NONE;
        end
    endgenerate

    // losers stay visible as pending while their source holds
    assign pend_d = src_req & lvl_live;

    always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            req_q    <= 1'b0;
            level_q  <= LVL_RESET;
            vector_q <= '0;
            addr_q   <= TB_RESET;
            pend_q   <= '0;
        end else if (sync_clr_i) begin
            req_q    <= 1'b0;
            level_q  <= LVL_RESET;
            vector_q <= '0;
            addr_q   <= {tb_q, {TB_LO_W{1'b0}}};
            pend_q   <= '0;
        end else begin
            req_q    <= arb_hit;
            level_q  <= arb_hit ? arb_level : LVL_RESET;
            vector_q <= arb_hit ? arb_index : '0;
            addr_q   <= slot_addr(tb_q, arb_hit ? arb_index : '0);
            pend_q   <= pend_d;
        end
    end

    always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            exc_req_q  <= 1'b0;
            exc_vec_q  <= VEC_RESET;
            exc_addr_q <= TB_RESET;
        end else begin
            exc_req_q  <= exc_any;
            exc_vec_q  <= exc_vec;
            exc_addr_q <= slot_addr(tb_q, exc_vec);
        end
    end

    assign irq_req_o    = req_q;
    assign irq_level_o  = level_q;
    assign irq_vector_o = vector_q;
    assign irq_addr_o   = addr_q;
    assign pending_o    = pend_q;
    assign exc_req_o    = exc_req_q;
    assign exc_vector_o = exc_vec_q;
    assign exc_addr_o   = exc_addr_q;
    assign table_base_o = {tb_q, {TB_LO_W{1'b0}}};

endmodule

// ---- piv_pkg.sv ----
package piv_pkg;

    // vector numbers and field widths
    localparam int VEC_W   = 5;
    localparam int LVL_W   = 3;
    localparam int NUM_VEC = 17;
    localparam int ADDR_W  = 24;
    localparam int TB_LO_W = 8;

    // table base after reset; low byte is always zero
    localparam logic [ADDR_W-1:0] TB_RESET  = 24'h008000;
    localparam logic [LVL_W-1:0]  LVL_RESET = 3'h0;
    localparam logic [LVL_W-1:0]  LVL_NONE  = 3'h0;
    localparam int                SLOT_SH   = 2;

    // slot numbers, fixed and maskable
    localparam logic [VEC_W-1:0] VEC_RESET    = 5'h00;
    localparam logic [VEC_W-1:0] VEC_MISALIGN = 5'h01;
    localparam logic [VEC_W-1:0] VEC_NMI      = 5'h02;
    localparam logic [VEC_W-1:0] VEC_COMPILER = 5'h03;
    localparam logic [VEC_W-1:0] VEC_SUPPLY   = 5'h04;
    localparam logic [VEC_W-1:0] VEC_PORT     = 5'h05;
    localparam logic [VEC_W-1:0] VEC_UNUSED   = 5'h06;
    localparam logic [VEC_W-1:0] VEC_CLKGEN   = 5'h07;
    localparam logic [VEC_W-1:0] VEC_RTC      = 5'h08;
    localparam logic [VEC_W-1:0] VEC_TMR0     = 5'h09;
    localparam logic [VEC_W-1:0] VEC_UART     = 5'h0a;
    localparam logic [VEC_W-1:0] VEC_TMR1     = 5'h0b;
    localparam logic [VEC_W-1:0] VEC_SSP      = 5'h0c;
    localparam logic [VEC_W-1:0] VEC_I2C      = 5'h0d;
    localparam logic [VEC_W-1:0] VEC_PWM      = 5'h0e;
    localparam logic [VEC_W-1:0] VEC_TMR2     = 5'h0f;
    localparam logic [VEC_W-1:0] VEC_TMR3     = 5'h10;

    // cause counts of merged sources, and timer count
    localparam int CLG_N  = 5;
    localparam int RTC_N  = 4;
    localparam int UART_N = 7;
    localparam int SSP_N  = 4;
    localparam int I2C_N  = 8;
    localparam int PWM_N  = 4;
    localparam int TMR_N  = 4;

endpackage

// ---- piv_arbiter.sv ----
`timescale 1ns/1ps

module piv_arbiter #(
    parameter int N  = 17,
    parameter int LW = 3,
    parameter int VW = 5
) (
    input  wire logic [N-1:0]    req_i,
    input  wire logic [N*LW-1:0] level_i,
    output logic                 hit_o,
    output logic [LW-1:0]        level_o,
    output logic [VW-1:0]        index_o
);

    logic          bv [0:N];
    logic [LW-1:0] bl [0:N];
    logic [VW-1:0] bi [0:N];

    assign bv[0] = 1'b0;
    assign bl[0] = '0;
    assign bi[0] = '0;

    // scan upward; only a strictly higher level displaces, so ties
    // stay with the smaller index
    generate
        for (genvar i = 0; i < N; i++) begin : g_scan
            logic [LW-1:0] lv;
            logic          take;
            assign lv   = level_i[i*LW +: LW];
            assign take = req_i[i] && (lv != '0) &&
                          (!bv[i] || (lv > bl[i]));
            assign bv[i+1] = bv[i] | take;
            assign bl[i+1] = take ? lv : bl[i];
            assign bi[i+1] = take ? VW'(i) : bi[i];
        end
    endgenerate

    assign hit_o   = bv[N];
    assign level_o = bl[N];
    assign index_o = bi[N];

endmodule

// ---- piv_monitor.sv ----
`timescale 1ns/1ps
module piv_monitor (
    input wire logic                        clk_sys_i,
    input wire logic                        reset_n_i,
    input wire logic                        sync_clr_i,
    input wire logic                        por_i,
    input wire logic                        wdt_ovf_i,
    input wire logic                        wdt_nmi_sel_i,
    input wire logic                        irq_req_o,
    input wire logic [piv_pkg::LVL_W-1:0]   irq_level_o,
    input wire logic [piv_pkg::VEC_W-1:0]   irq_vector_o,
    input wire logic [piv_pkg::ADDR_W-1:0]  irq_addr_o,
    input wire logic [piv_pkg::NUM_VEC-1:0] pending_o,
    input wire logic [piv_pkg::VEC_W-1:0]   exc_vector_o,
    input wire logic                        exc_req_o,
    input wire logic [piv_pkg::ADDR_W-1:0]  exc_addr_o,
    input wire logic [piv_pkg::ADDR_W-1:0]  table_base_o
);
    import piv_pkg::*;
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (!reset_n_i);
    ////////////////////////////////////////////////////////////////////
    chk_req_level: assert property (
        irq_req_o |-> irq_level_o != LVL_NONE)
        else $error("request forwarded at level zero");
    chk_idle_zero: assert property (
        !irq_req_o |-> irq_level_o == LVL_NONE
        && irq_vector_o == VEC_RESET && !(|pending_o))
        else $error("idle outputs not cleared");
    // guarded by a stable base so a base write may take its one edge
    chk_irq_addr: assert property ($stable(table_base_o) |->
        irq_addr_o == table_base_o + {irq_vector_o, 2'h0})
        else $error("vector address not base plus four n");
    chk_exc_addr: assert property ($stable(table_base_o) |->
        exc_addr_o == table_base_o + {exc_vector_o, 2'h0})
        else $error("exception address not base plus four n");
    chk_base_align: assert property (table_base_o[7:0] == 8'h00)
        else $error("table base not on 256 byte boundary");
    chk_slot_unused: assert property (!(|(pending_o[6:0] & 7'h4f)))
        else $error("reserved slot pending");
    chk_winner_pend: assert property (
        irq_req_o |-> pending_o[irq_vector_o])
        else $error("forwarded vector not pending");
    chk_sync_clear: assert property (
        sync_clr_i |=> !irq_req_o && !(|pending_o))
        else $error("sync clear left a request");
    chk_reset_slot: assert property (
        (por_i || (wdt_ovf_i && !wdt_nmi_sel_i))
        |=> exc_req_o && exc_vector_o == VEC_RESET)
        else $error("reset cause not on slot zero");
endmodule

bind piv_top piv_monitor i_piv_monitor (.clk_sys_i, .reset_n_i, .sync_clr_i,
    .por_i, .wdt_ovf_i, .wdt_nmi_sel_i, .irq_req_o, .irq_level_o,
    .irq_vector_o, .irq_addr_o, .pending_o, .exc_vector_o, .exc_req_o,
    .exc_addr_o, .table_base_o);

// ---- piv_cpu_model.sv ----
`timescale 1ns/1ps
// cpu side: takes any request above its own level each cycle
module piv_cpu_model #(
    parameter logic [2:0] PSR_LEVEL = 3'h0
) (
    input  wire logic                      clk_sys_i,
    input  wire logic                      reset_n_i,
    input  wire logic                      irq_req_i,
    input  wire logic [piv_pkg::LVL_W-1:0] irq_level_i,
    input  wire logic [piv_pkg::VEC_W-1:0] irq_vector_i,
    output logic      [piv_pkg::VEC_W-1:0] taken_vec_o
);
    import piv_pkg::*;
    always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            taken_vec_o <= VEC_RESET;
        end else if (irq_req_i && irq_level_i > PSR_LEVEL) begin
            taken_vec_o <= irq_vector_i;
        end
    end
endmodule

// ---- prioritized_interrupt_vectoring_tb.sv ----
`timescale 1ns/1ps
module prioritized_interrupt_vectoring_tb;
    import piv_pkg::*;
    logic        clk_sys_i, reset_n_i, sync_clr_i, lvl_wr_i, tb_wr_i;
    logic        rst_pin_n_i, por_i, key_rst_i, supply_rst_i, wdt_ovf_i;
    logic        wdt_nmi_sel_i, misalign_i, supply_low_i, port_irq_i;
    logic [4:0]  lvl_sel_i, clkgen_cause_i, irq_vector_o, exc_vector_o;
    logic [4:0]  taken_vec;
    logic [2:0]  lvl_data_i, irq_level_o;
    logic [15:0] tb_data_i;
    logic [3:0]  rtc_cause_i, tmr_unf_i, ssp_cause_i, pwm_cause_i;
    logic [6:0]  uart_cause_i;
    logic [7:0]  i2c_cause_i;
    logic [23:0] irq_addr_o, exc_addr_o, table_base_o, base_exp;
    logic [16:0] pending_o;
    logic        irq_req_o, exc_req_o;
    int          err_total, n_compared, cycles;

    piv_top i_piv_top (.*);
    piv_cpu_model i_piv_cpu_model (.clk_sys_i, .reset_n_i,
        .irq_req_i(irq_req_o),
        .irq_level_i(irq_level_o), .irq_vector_i(irq_vector_o),
        .taken_vec_o(taken_vec));
    ////////////////////////////////////////////////////////////////////
    task automatic test_done();
        if (err_total == 0 && n_compared > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    task automatic check(input logic ok, input string what);
        n_compared++;
        if (ok !== 1'b1) begin
            err_total++;
            $display("BAD %0t %s", $time, what);
        end
    endtask
    task automatic cmp(input logic r, input logic [2:0] l,
        input logic [4:0] v);
        check(irq_req_o === r && irq_level_o === l && irq_vector_o === v
            && irq_addr_o === base_exp + {v, 2'h0}, "irq outputs");
    endtask
    // sources are levels: set at one edge, seen after the next
    task automatic drive(input logic [16:0] s, input int k);
        @(posedge clk_sys_i);
        supply_low_i   <= s[4];
        port_irq_i     <= s[5];
        clkgen_cause_i <= s[7] ? 5'h01 << (k % CLG_N) : 5'h00;
        rtc_cause_i    <= s[8] ? 4'h1 << (k % RTC_N) : 4'h0;
        tmr_unf_i      <= {s[16], s[15], s[11], s[9]};
        uart_cause_i   <= s[10] ? 7'h01 << (k % UART_N) : 7'h00;
        ssp_cause_i    <= s[12] ? 4'h1 << (k % SSP_N) : 4'h0;
        i2c_cause_i    <= s[13] ? 8'h01 << (k % I2C_N) : 8'h00;
        pwm_cause_i    <= s[14] ? 4'h1 << (k % PWM_N) : 4'h0;
        @(posedge clk_sys_i);
        #1;
    endtask
    task automatic set_lvl(input int v, input logic [2:0] l);
        @(posedge clk_sys_i);
        lvl_wr_i   <= 1'b1;
        lvl_sel_i  <= v[4:0];
        lvl_data_i <= l;
        @(posedge clk_sys_i);
        lvl_wr_i   <= 1'b0;
    endtask
    ////////////////////////////////////////////////////////////////////
    task automatic s_map();
        check(table_base_o === 24'h008000 && exc_req_o === 1'b0, "reset");
        drive(17'h00200, 0);
        cmp(1'b0, 3'h0, 5'h00);
        for (int v = 4; v <= 16; v++) if (v != 6) set_lvl(v, 3'h2);
        for (int v = 4; v <= 16; v++) begin
            for (int k = 0; k < 8; k++) begin
                if (v != 6) begin
                    drive(17'h1 << v, k);
                    cmp(1'b1, 3'h2, v[4:0]);
                end
            end
        end
    endtask
    task automatic s_priority();
        set_lvl(9, 3'h3);
        set_lvl(10, 3'h5);
        drive(17'h00200, 0);
        cmp(1'b1, 3'h3, VEC_TMR0);
        drive(17'h00600, 0);
        cmp(1'b1, 3'h5, VEC_UART);
        check(pending_o[9] === 1'b1 && pending_o[10] === 1'b1, "held");
        drive(17'h00200, 0);
        cmp(1'b1, 3'h3, VEC_TMR0);
        check(taken_vec === VEC_UART, "cpu took");
        drive(17'h00600, 0);
        drive(17'h00400, 0);
        cmp(1'b1, 3'h5, VEC_UART);
        check(pending_o[9] === 1'b0, "dropped");
        set_lvl(4, 3'h6);
        set_lvl(5, 3'h6);
        drive(17'h00030, 0);
        cmp(1'b1, 3'h6, VEC_SUPPLY);
        set_lvl(16, 3'h7);
        drive(17'h10010, 0);
        cmp(1'b1, 3'h7, VEC_TMR3);
    endtask
    task automatic s_clear_base();
        drive(17'h00200, 0);
        @(posedge clk_sys_i);
        sync_clr_i <= 1'b1;
        @(posedge clk_sys_i);
        sync_clr_i <= 1'b0;
        #1;
        cmp(1'b0, 3'h0, 5'h00);
        @(posedge clk_sys_i);
        tb_wr_i   <= 1'b1;
        tb_data_i <= 16'h0123;
        @(posedge clk_sys_i);
        tb_wr_i  <= 1'b0;
        base_exp = 24'h012300;
        drive(17'h00200, 0);
        cmp(1'b1, 3'h3, VEC_TMR0);
        check(table_base_o === base_exp, "base");
        drive(17'h00000, 0);
        cmp(1'b0, 3'h0, 5'h00);
    endtask
    task automatic s_exc();
        logic [4:0] ev;
        for (int i = 0; i < 8; i++) begin
            ev = (i == 6) ? VEC_NMI : (i >= 5) ? VEC_MISALIGN : VEC_RESET;
            @(posedge clk_sys_i);
            rst_pin_n_i   <= (i != 0);
            por_i         <= (i == 1);
            key_rst_i     <= (i == 2);
            supply_rst_i  <= (i == 3);
            wdt_ovf_i     <= (i == 4 || i >= 6);
            wdt_nmi_sel_i <= (i >= 6);
            misalign_i    <= (i == 5 || i == 7);
            repeat (4) @(posedge clk_sys_i);
            #1;
            check(exc_req_o === 1'b1 && exc_vector_o === ev
                && exc_addr_o === base_exp + {ev, 2'h0}, "exception");
            @(posedge clk_sys_i);
            {por_i, key_rst_i, supply_rst_i, wdt_ovf_i, misalign_i} <= '0;
            rst_pin_n_i <= 1'b1;
            repeat (4) @(posedge clk_sys_i);
        end
    endtask
    ////////////////////////////////////////////////////////////////////
    initial begin
        clk_sys_i = 1'b0;
        forever #20 clk_sys_i = ~clk_sys_i;
    end
    // a hang counts as a mismatch and still reaches the verdict
    always @(posedge clk_sys_i) begin
        cycles++;
        if (cycles == 5000) begin
            err_total++;
            test_done();
        end
    end
    initial begin
        {reset_n_i, sync_clr_i, lvl_wr_i, tb_wr_i, lvl_sel_i, lvl_data_i} = '0;
        {por_i, key_rst_i, supply_rst_i, wdt_ovf_i, wdt_nmi_sel_i} = '0;
        {misalign_i, supply_low_i, port_irq_i, clkgen_cause_i} = '0;
        {rtc_cause_i, tmr_unf_i, uart_cause_i, ssp_cause_i} = '0;
        {i2c_cause_i, pwm_cause_i, tb_data_i} = '0;
        rst_pin_n_i = 1'b1;
        base_exp = 24'h008000;
        repeat (8) @(posedge clk_sys_i);
        reset_n_i <= 1'b1;
        @(posedge clk_sys_i);
        #1;
        cmp(1'b0, 3'h0, 5'h00);
        s_map();
        s_priority();
        s_clear_base();
        s_exc();
        test_done();
    end
endmodule
